/* File: i2cs_slave.sv */
// serial register port slave: bus logic on link clock, register side on ref clock
`timescale 1ns/10ps
module i2cs_slave
  import i2cs_pkg::*;
(
  // clocks and reset
  input wire logic ref_clk_i,
  input wire logic link_clk_i,
  input wire logic rst_i,
  // address strap pins
  input wire logic port_select_pin_low_bit_i,
  input wire logic port_select_pin_high_bit_i,
  // bus side
  i2cs_if.device bus,
  // register access side
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [15:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  input wire logic [7:0] reg_rdata_i
);

  // bus-side states
  typedef enum logic [5:0] {
    I2CS_IDLE = 6'h01,
    I2CS_ADDR = 6'h02,
    I2CS_RX = 6'h04,
    I2CS_ACK = 6'h08,
    I2CS_TX = 6'h10,
    I2CS_TXACK = 6'h20
  } i2cs_state_e;

  // all state of the link-clock domain
  typedef struct packed {
    logic scl_s1;          // scl synchroniser, first stage
    logic scl_s2;          // scl synchroniser, second stage
    logic scl_d;           // scl one cycle older
    logic sda_s1;          // sda synchroniser, first stage
    logic sda_s2;          // sda synchroniser, second stage
    logic sda_d;           // sda one cycle older
    logic [1:0] ps_s1;     // strap synchroniser, first stage
    logic [1:0] ps_s2;     // strap synchroniser, second stage
    logic [1:0] own;       // captured low address bits
    logic [1:0] strap_cnt; // cycles since reset release
    i2cs_state_e st;       // bus state
    logic [3:0] bitn;      // bit position in byte
    logic [7:0] sh;        // byte shift register
    logic [1:0] idx;       // byte index after address byte
    logic rw;              // direction of current transfer
    logic [15:0] ptr;      // register address pointer
    logic sda_drive;       // pulling sda low
    logic req_tgl;         // request toggle towards ref domain
    logic req_we;          // request is a write
    logic [15:0] req_addr; // request address
    logic [7:0] req_data;  // request write data
    logic ack_s1;          // answer toggle synchroniser, first stage
    logic ack_s2;          // answer toggle synchroniser, second stage
    logic ack_d;           // answer toggle one cycle older
    logic [7:0] rd_buf;    // last read data from ref domain
  } i2cs_link_s;

  // all state of the ref-clock domain
  typedef struct packed {
    logic req_s1;          // request toggle synchroniser, first stage
    logic req_s2;          // request toggle synchroniser, second stage
    logic req_d;           // request toggle one cycle older
    logic wr;              // write strobe
    logic rd;              // read strobe
    logic [15:0] addr;     // register address
    logic [7:0] wdata;     // write data
    logic [7:0] rdata;     // captured read data
    logic ack_tgl;         // answer toggle towards link domain
  } i2cs_ref_s;

  i2cs_link_s l;
  i2cs_link_s next_l;
  i2cs_ref_s r;
  i2cs_ref_s next_r;

  // hands a register request to the ref domain by flipping the toggle
  function automatic i2cs_link_s i2cs_req(input i2cs_link_s s, input logic we,
                                          input logic [15:0] a, input logic [7:0] d);
    i2cs_link_s o;
    o = s;
    o.req_tgl = ~s.req_tgl;
    o.req_we = we;
    o.req_addr = a;
    o.req_data = d;
    return o;
  endfunction : i2cs_req

  // bus events from the synchronised lines
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;

  // link-domain next state
  always_comb
  begin
    next_l = l;
    next_l.scl_s1 = bus.scl;
    next_l.scl_s2 = l.scl_s1;
    next_l.scl_d = l.scl_s2;
    next_l.sda_s1 = bus.sda;
    next_l.sda_s2 = l.sda_s1;
    next_l.sda_d = l.sda_s2;
    next_l.ps_s1 = {port_select_pin_high_bit_i, port_select_pin_low_bit_i};
    next_l.ps_s2 = l.ps_s1;
    next_l.ack_s1 = r.ack_tgl;
    next_l.ack_s2 = l.ack_s1;
    next_l.ack_d = l.ack_s2;
    // read data is stable once the answer toggle has crossed
    if (l.ack_s2 != l.ack_d)
    begin
      next_l.rd_buf = r.rdata;
    end
    // strap pins caught once, shortly after reset release
    if (l.strap_cnt != 2'h3)
    begin
      next_l.strap_cnt = l.strap_cnt + 2'h1;
      if (l.strap_cnt == I2CS_STRAP_CYC)
      begin
        // both pins high give 01, low pin alone gives 00; high pin alone gives 11
        next_l.own = {l.ps_s2[1] & ~l.ps_s2[0], l.ps_s2[1]};
      end
    end
    scl_rise = l.scl_s2 & ~l.scl_d;
    scl_fall = ~l.scl_s2 & l.scl_d;
    start_c = l.scl_s2 & l.scl_d & l.sda_d & ~l.sda_s2;
    stop_c = l.scl_s2 & l.scl_d & ~l.sda_d & l.sda_s2;
    case (l.st)
      I2CS_IDLE:
      begin
        // wait for a start; sda stays released
        next_l.sda_drive = 1'b0;
      end
      I2CS_ADDR, I2CS_RX:
      begin
        // sample on rising scl, act on the fall after the eighth bit
        if (scl_rise && l.bitn < I2CS_BYTE_BITS)
        begin
          next_l.sh = {l.sh[6:0], l.sda_s2};
          next_l.bitn = l.bitn + 4'h1;
        end
        else if (scl_fall && l.bitn == I2CS_BYTE_BITS)
        begin
          if (l.st == I2CS_ADDR)
          begin
            // address byte: own address only
            if (l.sh[7:1] == {I2CS_ADDR_HI, l.own})
            begin
              next_l.sda_drive = 1'b1;
              next_l.st = I2CS_ACK;
              next_l.rw = l.sh[0];
              next_l.idx = 2'h0;
              if (l.sh[0] == I2CS_DIR_READ)
              begin
                // fetch the first byte at the current pointer
                next_l = i2cs_req(next_l, 1'b0, l.ptr, 8'h00);
              end
            end
            else
            begin
              next_l.st = I2CS_IDLE;
            end
          end
          else
          begin
            // data-direction byte from the master
            if (l.idx == 2'h0)
            begin
              next_l.ptr[15:8] = l.sh;
              next_l.idx = 2'h1;
            end
            else if (l.idx == 2'h1)
            begin
              next_l.ptr[7:0] = l.sh;
              next_l.idx = 2'h2;
            end
            else
            begin
              next_l = i2cs_req(next_l, 1'b1, l.ptr, l.sh);
              next_l.ptr = l.ptr + 16'h0001;
            end
            next_l.sda_drive = 1'b1;
            next_l.st = I2CS_ACK;
          end
        end
      end
      I2CS_ACK:
      begin
        // acknowledge held through the ninth pulse
        if (scl_fall)
        begin
          next_l.bitn = 4'h0;
          if (l.rw == I2CS_DIR_READ)
          begin
            next_l.sh = l.rd_buf;
            next_l.ptr = l.ptr + 16'h0001;
            next_l.sda_drive = ~l.rd_buf[7];
            next_l.st = I2CS_TX;
          end
          else
          begin
            next_l.sda_drive = 1'b0;
            next_l.st = I2CS_RX;
          end
        end
      end
      I2CS_TX:
      begin
        // shift out on falling scl, MSB first
        if (scl_fall)
        begin
          if (l.bitn == I2CS_BYTE_BITS - 4'h1)
          begin
            next_l.sda_drive = 1'b0;
            next_l.bitn = 4'h0;
            next_l.st = I2CS_TXACK;
          end
          else
          begin
            next_l.sh = {l.sh[6:0], 1'b0};
            next_l.bitn = l.bitn + 4'h1;
            next_l.sda_drive = ~l.sh[6];
          end
        end
      end
      I2CS_TXACK:
      begin
        // master answers on the ninth pulse
        if (scl_rise)
        begin
          if (l.sda_s2)
          begin
            next_l.st = I2CS_IDLE;
          end
          else
          begin
            next_l = i2cs_req(next_l, 1'b0, l.ptr, 8'h00);
          end
        end
        else if (scl_fall)
        begin
          next_l.sh = l.rd_buf;
          next_l.ptr = l.ptr + 16'h0001;
          next_l.sda_drive = ~l.rd_buf[7];
          next_l.st = I2CS_TX;
        end
      end
      default:
      begin
        next_l.st = I2CS_IDLE;
        next_l.sda_drive = 1'b0;
      end
    endcase
    // start or stop overrides everything; half bytes are dropped
    if (start_c)
    begin
      next_l.st = I2CS_ADDR;
      next_l.bitn = 4'h0;
      next_l.sda_drive = 1'b0;
    end
    else if (stop_c)
    begin
      next_l.st = I2CS_IDLE;
      next_l.sda_drive = 1'b0;
    end
  end

  // link-domain register
  always_ff @(posedge link_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      l <= '{st: I2CS_IDLE, default: '0};
    end
    else
    begin
      l <= next_l;
    end
  end

  // ref-domain next state: perform one request per toggle
  always_comb
  begin
    next_r = r;
    next_r.req_s1 = l.req_tgl;
    next_r.req_s2 = r.req_s1;
    next_r.req_d = r.req_s2;
    next_r.wr = 1'b0;
    next_r.rd = 1'b0;
    // request fields are stable while the toggle crosses
    if (r.req_s2 != r.req_d)
    begin
      next_r.addr = l.req_addr;
      next_r.wdata = l.req_data;
      next_r.wr = l.req_we;
      next_r.rd = ~l.req_we;
    end
    // read data answered in the strobe cycle, then signalled back
    if (r.rd)
    begin
      next_r.rdata = reg_rdata_i;
      next_r.ack_tgl = ~r.ack_tgl;
    end
  end

  // ref-domain register
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      r <= '0;
    end
    else
    begin
      r <= next_r;
    end
  end

  // outputs; scl is never driven by this end
  assign reg_wr_o = r.wr;
  assign reg_rd_o = r.rd;
  assign reg_addr_o = r.addr;
  assign reg_wdata_o = r.wdata;
  assign bus.d_sda_o = 1'b0;
  assign bus.d_sda_oe_n = ~l.sda_drive;

endmodule : i2cs_slave

/* File: i2cs_pkg.sv */
// constants shared by the serial register port master and slave
// Functional notes
// - data changes only while SCL low
// - start and stop detected on sampled lines
// - eight bits MSB first, then acknowledge slot
// - receiver pulls SDA low on ninth pulse
// - not-acknowledge returns slave to idle
// - seven-bit address then direction bit
// - acknowledge only own address, else idle
// - any start restarts address reception
// - two register address bytes, high first
// - following data bytes written, unlimited count
// - read data follows address acknowledge
// - address-only write just loads the pointer
// - repeated start read uses supplied address
// - master ends read with nack, stop
// - nacked read byte ends transfer, releases SDA
// - master stops after last write acknowledge
// - partial bytes discarded, never written
// - address 10101 plus two strap pins; code decodes the pins: both high 01, low alone 00, high alone 11
// - slave never drives SCL
package i2cs_pkg;
  // fixed upper part of the slave address
  localparam logic [4:0] I2CS_ADDR_HI = 5'h15;
  // direction bit value for a master read
  localparam logic I2CS_DIR_READ = 1'b1;
  // bits per byte on the wire
  localparam logic [3:0] I2CS_BYTE_BITS = 4'h8;
  // strap capture happens this many cycles after reset
  localparam logic [1:0] I2CS_STRAP_CYC = 2'h2;
  // host clock period and bus clock period
  localparam int I2CS_CLK_PERIOD_NS = 100;
  localparam int I2CS_SCL_PERIOD_NS = 10000;
  // host cycles per quarter of a bus clock period
  localparam int I2CS_QUARTER_CYC = I2CS_SCL_PERIOD_NS / (4 * I2CS_CLK_PERIOD_NS);
  // master commands
  typedef enum logic [1:0] {
    I2CS_CMD_START = 2'h0,
    I2CS_CMD_WRITE = 2'h1,
    I2CS_CMD_READ = 2'h2,
    I2CS_CMD_STOP = 2'h3
  } i2cs_cmd_e;
endpackage : i2cs_pkg

/* File: i2cs_if.sv */
// two-wire bus joining master and slave, with open-drain resolution
`timescale 1ns/10ps
interface i2cs_if;
  // master pins
  logic h_scl_o;
  logic h_scl_oe_n;
  logic h_sda_o;
  logic h_sda_oe_n;
  // slave pins
  logic d_sda_o;
  logic d_sda_oe_n;
  // resolved wire levels, pulled up when nobody drives
  logic scl;
  logic sda;
  assign scl = h_scl_oe_n | h_scl_o;
  assign sda = (h_sda_oe_n | h_sda_o) & (d_sda_oe_n | d_sda_o);
  // master end
  modport host (output h_scl_o, h_scl_oe_n, h_sda_o, h_sda_oe_n, input scl, sda);
  // slave end
  modport device (output d_sda_o, d_sda_oe_n, input scl, sda);
endinterface : i2cs_if

/* File: i2cs_master.sv */
// serial register port master: byte-level command engine making SCL
`timescale 1ns/10ps
module i2cs_master
  import i2cs_pkg::*;
#(
  parameter int QUARTER = I2CS_QUARTER_CYC
)
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // command side
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire logic [1:0] cmd_i,
  input wire logic [7:0] wdata_i,
  input wire logic ack_i,
  output logic done_o,
  output logic [7:0] rdata_o,
  output logic nack_o,
  // bus side
  i2cs_if.host bus
);

  // quarter timer must outlast the sda synchroniser
  if (QUARTER < 4 || QUARTER > 65535)
  begin : g_chk
    $error("QUARTER out of range");
  end

  // engine states
  typedef enum logic [3:0] {
    I2CS_M_IDLE = 4'h1,
    I2CS_M_START = 4'h2,
    I2CS_M_BYTE = 4'h4,
    I2CS_M_STOP = 4'h8
  } i2cs_mstate_e;

  // all master state
  typedef struct packed {
    i2cs_mstate_e st;   // engine state
    logic [15:0] tq;    // cycles within quarter
    logic [1:0] q;      // quarter within bit
    logic [3:0] bitn;   // bits done in byte
    logic [8:0] sh;     // out bits, sampled bits shift in
    logic [7:0] rdata;  // last byte read
    logic nack;         // last ack slot was high
    logic done;         // command finished pulse
    logic scl_low;      // pulling scl low
    logic sda_low;      // pulling sda low
    logic sda_s1;       // sda synchroniser, first stage
    logic sda_s2;       // sda synchroniser, second stage
  } i2cs_master_s;

  i2cs_master_s m;
  i2cs_master_s next_m;

  // next state of the engine
  always_comb
  begin
    next_m = m;
    next_m.done = 1'b0;
    next_m.sda_s1 = bus.sda;
    next_m.sda_s2 = m.sda_s1;
    if (m.st == I2CS_M_IDLE)
    begin
      // take a command; first quarter has scl low
      if (cmd_valid_i)
      begin
        next_m.tq = 16'h0000;
        next_m.q = 2'h0;
        next_m.bitn = 4'h0;
        next_m.scl_low = 1'b1;
        case (cmd_i)
          I2CS_CMD_START:
          begin
            next_m.st = I2CS_M_START;
            next_m.sda_low = 1'b0;
          end
          I2CS_CMD_WRITE:
          begin
            next_m.st = I2CS_M_BYTE;
            next_m.sh = {wdata_i, 1'b1};
            next_m.sda_low = ~wdata_i[7];
          end
          I2CS_CMD_READ:
          begin
            next_m.st = I2CS_M_BYTE;
            next_m.sh = {8'hFF, ~ack_i};
            next_m.sda_low = 1'b0;
          end
          default:
          begin
            next_m.st = I2CS_M_STOP;
            next_m.sda_low = 1'b1;
          end
        endcase
      end
    end
    else if (m.tq != 16'(QUARTER - 1))
    begin
      next_m.tq = m.tq + 16'h0001;
    end
    else
    begin
      // quarter boundary: step the wave
      next_m.tq = 16'h0000;
      next_m.q = m.q + 2'h1;
      case (m.st)
        I2CS_M_START:
        begin
          case (m.q)
            2'h0: next_m.scl_low = 1'b0;
            2'h1: next_m.sda_low = 1'b1;
            2'h2: next_m.scl_low = 1'b1;
            default:
            begin
              next_m.st = I2CS_M_IDLE;
              next_m.done = 1'b1;
            end
          endcase
        end
        I2CS_M_BYTE:
        begin
          case (m.q)
            2'h0: next_m.scl_low = 1'b0;
            2'h1: next_m.sh = {m.sh[7:0], m.sda_s2};
            2'h2: next_m.scl_low = 1'b1;
            default:
            begin
              // sda changes only now, with scl low
              next_m.bitn = m.bitn + 4'h1;
              if (m.bitn == I2CS_BYTE_BITS)
              begin
                next_m.st = I2CS_M_IDLE;
                next_m.done = 1'b1;
                next_m.rdata = m.sh[8:1];
                next_m.nack = m.sh[0];
                next_m.sda_low = 1'b0;
              end
              else
              begin
                next_m.sda_low = ~m.sh[8];
              end
            end
          endcase
        end
        I2CS_M_STOP:
        begin
          case (m.q)
            2'h0: next_m.scl_low = 1'b0;
            2'h1: next_m.sda_low = 1'b0;
            2'h2: next_m.sda_low = 1'b0;
            default:
            begin
              next_m.st = I2CS_M_IDLE;
              next_m.done = 1'b1;
            end
          endcase
        end
        default:
        begin
          next_m.st = I2CS_M_IDLE;
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      m <= '{st: I2CS_M_IDLE, default: '0};
    end
    else
    begin
      m <= next_m;
    end
  end

  // outputs
  assign cmd_ready_o = (m.st == I2CS_M_IDLE);
  assign done_o = m.done;
  assign rdata_o = m.rdata;
  assign nack_o = m.nack;
  assign bus.h_scl_o = 1'b0;
  assign bus.h_scl_oe_n = ~m.scl_low;
  assign bus.h_sda_o = 1'b0;
  assign bus.h_sda_oe_n = ~m.sda_low;

endmodule : i2cs_master

/* File: i2cs_bus_asserts.sv */
// bus checks on the two-wire link between master and slave
`timescale 1ns/10ps
module i2cs_bus_asserts
(
  // link clock and reset
  input wire logic link_clk_i,
  input wire logic rst_i,
  // slave address expected from the straps
  input wire logic [6:0] own_addr_i,
  // bus signals
  input wire logic h_scl_o,
  input wire logic h_sda_o,
  input wire logic d_sda_o,
  input wire logic d_sda_oe_n,
  input wire logic scl,
  input wire logic sda
);
  default clocking cb @(posedge link_clk_i); endclocking
  default disable iff (rst_i);
  // previous line samples and frame tracking
  logic scl_q, sda_q, first, rd, quiet;
  logic [3:0] cnt;
  logic [7:0] shreg;
  wire logic rise = scl & ~scl_q;
  wire logic start = scl & scl_q & sda_q & ~sda;
  wire logic stop = scl & scl_q & ~sda_q & sda;
  wire logic slot9 = rise & (cnt == 4'h8);
  // bit counter, first-byte shifter, idle flag
  always_ff @(posedge link_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      cnt <= 4'h0;
      first <= 1'b0;
      rd <= 1'b0;
      shreg <= 8'h00;
      quiet <= 1'b1;
    end
    else
    begin
      scl_q <= scl;
      sda_q <= sda;
      if (start)
      begin
        cnt <= 4'h0;
        first <= 1'b1;
        quiet <= 1'b0;
      end
      else if (stop)
      begin
        cnt <= 4'h0;
        quiet <= 1'b1;
      end
      else if (slot9)
      begin
        cnt <= 4'h0;
        first <= 1'b0;
        if (first)
          rd <= shreg[0];
        if (sda)
          quiet <= 1'b1;
      end
      else if (rise)
      begin
        cnt <= cnt + 4'h1;
        shreg <= {shreg[6:0], sda};
      end
    end
  end
  a_open_drain_only: assert property (!h_scl_o && !h_sda_o && !d_sda_o)
    else $error("a pin drives high");
  a_sda_steady_high: assert property (scl && scl_q |-> d_sda_oe_n == $past(d_sda_oe_n))
    else $error("slave moved sda while scl high");
  a_start_slave_free: assert property (start |-> d_sda_oe_n [*8])
    else $error("slave drives after start");
  a_idle_stays_free: assert property (quiet |-> d_sda_oe_n)
    else $error("idle slave drives sda");
  a_own_addr_ack: assert property (slot9 && first && shreg[7:1] == own_addr_i |-> !d_sda_oe_n)
    else $error("own address not acknowledged");
  a_other_addr_nack: assert property (slot9 && first && shreg[7:1] != own_addr_i |-> d_sda_oe_n)
    else $error("foreign address acknowledged");
  a_write_byte_ack: assert property (slot9 && !first && !rd && !quiet |-> !d_sda_oe_n)
    else $error("written byte not acknowledged");
  a_read_slot_free: assert property (slot9 && !first && rd |-> d_sda_oe_n)
    else $error("slave holds master ack slot");
endmodule : i2cs_bus_asserts

/* File: i2c_slave_reg_access_16bit_tb.sv */
// self-checking bench: master and slave joined over the two-wire bus
`timescale 1ns/10ps
`define CHK(g, e, m) \
  begin \
    checks_done++; \
    if ((g) !== (e)) \
    begin \
      mismatches++; \
      $display("Error at %0t: %s got %h exp %h", $time, m, g, e); \
    end \
  end
module i2c_slave_reg_access_16bit_tb;
  import i2cs_pkg::*;
  localparam int QTR = 20;
  // strap pins and the slave address they select
  logic [1:0] strap;
  logic [6:0] dev;
  // expected slave address for the two defined strap settings
  function automatic logic [6:0] own_addr(input logic [1:0] s);
    return {I2CS_ADDR_HI, (s == 2'h3) ? 2'h1 : 2'h0};
  endfunction : own_addr
  assign dev = own_addr(strap);
  // clocks, command port, register side
  logic ref_clk_i, link_clk_i, rst_i, cmd_valid_i, cmd_ready_o, ack_i, done_o, nack_o;
  logic reg_wr_o, reg_rd_o;
  logic [1:0] cmd_i;
  logic [7:0] wdata_i, rdata_o, reg_wdata_o, reg_rdata_i, d;
  logic [15:0] reg_addr_o, ptr, a;
  logic [7:0] mem [0:65535]; // registers behind the slave
  logic [7:0] ref_mem [0:65535]; // expected register contents
  logic [23:0] obs_q [$];
  logic [23:0] exp_q [$];
  int mismatches, checks_done, n, rd_cnt;
  i2cs_if bus_if();
  i2cs_master #(.QUARTER(QTR)) u_i2cs_master (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o), .cmd_i(cmd_i), .wdata_i(wdata_i),
    .ack_i(ack_i), .done_o(done_o), .rdata_o(rdata_o), .nack_o(nack_o), .bus(bus_if));
  i2cs_slave u_i2cs_slave (.ref_clk_i(ref_clk_i), .link_clk_i(link_clk_i), .rst_i(rst_i),
    .port_select_pin_low_bit_i(strap[0]), .port_select_pin_high_bit_i(strap[1]), .bus(bus_if),
    .reg_wr_o(reg_wr_o), .reg_rd_o(reg_rd_o), .reg_addr_o(reg_addr_o),
    .reg_wdata_o(reg_wdata_o), .reg_rdata_i(reg_rdata_i));
  i2cs_bus_asserts u_i2cs_bus_asserts (.link_clk_i(link_clk_i), .rst_i(rst_i), .own_addr_i(dev),
    .h_scl_o(bus_if.h_scl_o), .h_sda_o(bus_if.h_sda_o), .d_sda_o(bus_if.d_sda_o),
    .d_sda_oe_n(bus_if.d_sda_oe_n), .scl(bus_if.scl), .sda(bus_if.sda));
  // read data answers in the strobe cycle
  assign reg_rdata_i = mem[reg_addr_o];
  // register writes land and are logged
  always @(posedge ref_clk_i)
  begin
    if (reg_wr_o === 1'b1)
    begin
      mem[reg_addr_o] <= reg_wdata_o;
      obs_q.push_back({reg_addr_o, reg_wdata_o});
    end
    // read strobes are counted
    if (reg_rd_o === 1'b1)
    begin
      rd_cnt <= rd_cnt + 1;
    end
  end
  // clocks, unrelated in phase
  initial
  begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end
  initial
  begin
    link_clk_i = 1'b0;
    #3.3;
    forever #7.5 link_clk_i = ~link_clk_i;
  end
  // verdict and end of run
  task automatic wrap_up;
    $display("mismatches %0d checks_done %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : wrap_up
  // one master command, waits for done
  task automatic do_cmd(input logic [1:0] c, input logic [7:0] w, input logic k);
    int t;
    @(posedge ref_clk_i);
    cmd_valid_i <= 1'b1;
    cmd_i <= c;
    wdata_i <= w;
    ack_i <= k;
    @(posedge ref_clk_i);
    cmd_valid_i <= 1'b0;
    t = 0;
    do
    begin
      @(posedge ref_clk_i);
      #1;
      t++;
    end
    while (done_o !== 1'b1 && t < 50 * QTR);
    if (done_o !== 1'b1)
    begin
      mismatches++;
      $display("Error at %0t: command hung", $time);
      wrap_up();
    end
    `CHK(cmd_ready_o, 1'b1, "engine idle after done")
  endtask : do_cmd
  // byte write with expected ack slot
  task automatic wr(input logic [7:0] w, input logic k);
    do_cmd(I2CS_CMD_WRITE, w, 1'b0);
    `CHK(nack_o, ~k, "ack slot")
  endtask : wr
  // byte read against expected contents
  task automatic rd(input logic k);
    logic [7:0] e;
    e = ref_mem[ptr];
    do_cmd(I2CS_CMD_READ, 8'h00, k);
    `CHK(rdata_o, e, "read data")
    ptr++;
  endtask : rd
  // start, own address for write, register address
  task automatic hdr(input logic [15:0] r);
    do_cmd(I2CS_CMD_START, 8'h00, 1'b0);
    wr({dev, 1'b0}, 1'b1);
    wr(r[15:8], 1'b1);
    wr(r[7:0], 1'b1);
    ptr = r;
  endtask : hdr
  // compare logged writes with expected ones
  task automatic check_writes;
    logic [23:0] g;
    logic [23:0] e;
    repeat (10) @(posedge ref_clk_i);
    `CHK(obs_q.size(), exp_q.size(), "write count")
    while (exp_q.size() > 0 && obs_q.size() > 0)
    begin
      g = obs_q.pop_front();
      e = exp_q.pop_front();
      `CHK(g, e, "register write")
    end
    exp_q.delete();
    obs_q.delete();
  endtask : check_writes
  // burst write of random bytes
  task automatic wr_burst(input logic [15:0] r, input int cnt);
    hdr(r);
    repeat (cnt)
    begin
      d = 8'($urandom);
      wr(d, 1'b1);
      ref_mem[ptr] = d;
      exp_q.push_back({ptr, d});
      ptr++;
    end
    do_cmd(I2CS_CMD_STOP, 8'h00, 1'b0);
    check_writes();
  endtask : wr_burst
  // burst read, optionally combined with an address phase
  task automatic rd_burst(input int cnt, input logic comb, input logic [15:0] r);
    int s;
    if (comb)
      hdr(r);
    s = rd_cnt;
    do_cmd(I2CS_CMD_START, 8'h00, 1'b0);
    wr({dev, 1'b1}, 1'b1);
    repeat (cnt - 1) rd(1'b1);
    rd(1'b0);
    do_cmd(I2CS_CMD_STOP, 8'h00, 1'b0);
    check_writes();
    `CHK(rd_cnt - s, cnt, "read strobes")
  endtask : rd_burst
  // main sequence
  initial
  begin
    rst_i = 1'b1;
    cmd_valid_i = 1'b0;
    cmd_i = 2'h0;
    wdata_i = 8'h00;
    ack_i = 1'b0;
    mismatches = 0;
    checks_done = 0;
    rd_cnt = 0;
    strap = 2'h3;
    ptr = 16'h0000;
    for (int i = 0; i < 65536; i++)
    begin
      mem[i] = i[7:0] ^ i[15:8] ^ 8'hA5;
      ref_mem[i] = i[7:0] ^ i[15:8] ^ 8'hA5;
    end
    void'($urandom(20079));
    repeat (3) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    // write then read on from the advanced pointer
    wr_burst(16'h0120, 3);
    rd_burst(2, 1'b0, 16'h0000);
    wr_burst(16'hFFFF, 2);
    // address-only transfer, then plain read
    hdr(16'h0121);
    do_cmd(I2CS_CMD_STOP, 8'h00, 1'b0);
    check_writes();
    rd_burst(3, 1'b0, 16'h0000);
    // foreign address is ignored
    do_cmd(I2CS_CMD_START, 8'h00, 1'b0);
    wr({dev ^ 7'h01, 1'b0}, 1'b0);
    wr(8'h12, 1'b0);
    // header cut by repeated start writes nothing
    do_cmd(I2CS_CMD_START, 8'h00, 1'b0);
    wr({dev, 1'b0}, 1'b1);
    wr(8'h33, 1'b1);
    do_cmd(I2CS_CMD_START, 8'h00, 1'b0);
    do_cmd(I2CS_CMD_STOP, 8'h00, 1'b0);
    check_writes();
    // random bursts read back by combined reads
    repeat (3)
    begin
      a = 16'($urandom);
      n = 1 + $urandom % 3;
      wr_burst(a, n);
      rd_burst(n, 1'b1, a);
    end
    // second reset with the other strap setting moves the slave address
    @(posedge ref_clk_i);
    strap <= 2'h1;
    rst_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    do_cmd(I2CS_CMD_START, 8'h00, 1'b0);
    wr({own_addr(2'h3), 1'b0}, 1'b0);
    wr_burst(16'h0040, 2);
    rd_burst(2, 1'b1, 16'h0040);
    wrap_up();
  end
endmodule : i2c_slave_reg_access_16bit_tb
